// [shared/fmm_alu_map.svh]
`ifndef FMM_ALU_MAP_SVH
`define FMM_ALU_MAP_SVH

// Register bus word offsets
`define FMM_OFS_CTRL 4'h0
`define FMM_OFS_DEST 4'h4
`define FMM_OFS_SRC 4'h8
`define FMM_OFS_FLAGS 4'hc
// Control word fields
`define FMM_CTRL_OP_LSB 0
`define FMM_CTRL_OP_MSB 3
`define FMM_CTRL_WC 4
`define FMM_CTRL_WZ 5
`define FMM_CTRL_IMM 6
`define FMM_CTRL_CCODE_LSB 8
`define FMM_CTRL_CCODE_MSB 11
`define FMM_CTRL_ZCODE_LSB 12
`define FMM_CTRL_ZCODE_MSB 15
`define FMM_CTRL_LIT_LSB 16
`define FMM_CTRL_LIT_MSB 24
`define FMM_CTRL_GO 31
// Flags word fields
`define FMM_FLAG_Z 0
`define FMM_FLAG_C 1
`define FMM_FLAG_BUSY 2
// Codes that force a flag
`define FMM_FORCE_LOW_CODE 4'h0
`define FMM_FORCE_HIGH_CODE 4'hf
// Codes that copy or compare flags
`define FMM_COPY_CARRY_CODE 4'hc
`define FMM_INV_CARRY_CODE 4'h3
`define FMM_COPY_ZERO_CODE 4'ha
`define FMM_C_EQ_Z_CODE 4'h9
// Multiply latency in cycles
`define FMM_MUL_CYCLES 2'h2
`define FMM_LIT_W 9

`endif

// [shared/fmm_pkg.sv]
package fmm_pkg;

  typedef enum logic [3:0] {
    FMM_OP_NONE,
    FMM_OP_CARRY_MODIFY,
    FMM_OP_ZERO_FLAG_MODIFY,
    FMM_OP_BOTH_FLAGS_MODIFY,
    FMM_OP_COPY,
    FMM_OP_UNSIGNED_PRODUCT,
    FMM_OP_SIGNED_PRODUCT,
    FMM_OP_CARRY_BIT_MERGE,
    FMM_OP_INVERTED_CARRY_MERGE,
    FMM_OP_NIBBLE_MERGE,
    FMM_OP_BITPAIR_MERGE
  } fmm_op_t;

  typedef enum logic [1:0] {
    FMM_IDLE,
    FMM_MULT,
    FMM_DONE
  } fmm_phase_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] dest;
    logic [31:0] src;
    logic carry;
    logic zero;
    fmm_phase_t phase;
    logic [1:0] mcount;
    logic [31:0] product;
    logic [31:0] rdata;
    logic rvalid;
  } fmm_state_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fmm_avl_req_t;

endpackage : fmm_pkg

// [rtl/fmm_alu.sv]
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fmm_alu_map.svh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// - Each flag has its own 4-bit code field that defines its new value.
// - New flag is the code bit indexed by {carry, zero}.
// - Carry changes only with carry write, zero only with zero write.
// - Code 0000 forces the flag low.
// - Code 1111 forces the flag high.
// - 1100 copies carry, 0011 gives inverse carry.
// - 1010 copies zero, 0101 gives inverse zero.
// - 1000 is carry and zero, 0100 is carry and not zero.
// - 0010 is not carry and zero, 0001 neither flag set.
// - 1110 is carry or zero, 1101 is carry or not zero.
// - 1011 is not carry or zero, 0111 is not carry or not zero.
// - 1001 sets on carry equal zero, 0110 on carry differing.
// - Comparison names reuse the same codes.
// - Zero-first names encode like carry-first names.
// - One 16-entry evaluator serves flag modify and conditions.
// - Copy writes source; carry is source bit 31, zero on zero result.
// - Unsigned multiply of low 16 bits gives full 32-bit product.
// - Both multiplies complete within two clock cycles.
// - Signed multiply treats low 16 bits as two's complement.
// - Multiply zero flag set when the whole 32-bit dest or source value is zero.
// - Carry merge puts carry or inverse into masked destination bits.
// - Merge flags: carry is odd parity, zero on all-zero result.
// - Nibble merge copies non-zero source nibbles; flags unchanged.
// - Bit-pair merge copies non-zero source pairs; flags unchanged.
module fmm_alu (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] cond_code,
  output logic cond_true
);

  fmm_pkg::fmm_state_t st;
  fmm_pkg::fmm_state_t next_st;
  fmm_pkg::fmm_op_t op;
  fmm_pkg::fmm_avl_req_t req;
  logic [31:0] src_val;
  logic [3:0] ccode;
  logic [3:0] zcode;
  logic wc;
  logic wz;
  logic go;
  logic [31:0] res;
  logic res_c;
  logic res_z;
  logic do_c;
  logic do_z;
  logic [31:0] prod_u;
  logic [31:0] prod_s;
  logic wb;
  logic wr_ok;
  logic mod_c;

  ////////////////////////////////////////////////////////////////////////
  // Shared flag evaluator, also used for execution conditions
  function automatic logic fmm_eval(input logic [3:0] code,
                                    input logic c, input logic z);
    fmm_eval = code[{c, z}];
  endfunction : fmm_eval

  function automatic logic [31:0] fmm_lane(input logic [31:0] wr,
                                           input logic [31:0] old,
                                           input logic [3:0] be);
    integer i;
    fmm_lane = old;
    for (i = 0; i < 4; i++) begin
      if (be[i]) begin
        fmm_lane[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
  endfunction : fmm_lane

  assign cond_true = fmm_eval(cond_code, st.carry, st.zero);

  ////////////////////////////////////////////////////////////////////////
  // Operand decode
  assign req = '{avs_address, avs_read, avs_write, avs_writedata,
                 avs_byteenable};
  assign op = fmm_pkg::fmm_op_t'(
    st.ctrl[`FMM_CTRL_OP_MSB:`FMM_CTRL_OP_LSB]);
  assign ccode = st.ctrl[`FMM_CTRL_CCODE_MSB:`FMM_CTRL_CCODE_LSB];
  assign zcode = st.ctrl[`FMM_CTRL_ZCODE_MSB:`FMM_CTRL_ZCODE_LSB];
  assign wc = st.ctrl[`FMM_CTRL_WC];
  assign wz = st.ctrl[`FMM_CTRL_WZ];
  assign go = st.ctrl[`FMM_CTRL_GO];
  assign src_val = st.ctrl[`FMM_CTRL_IMM] ?
    {{(32-`FMM_LIT_W){1'b0}},
     st.ctrl[`FMM_CTRL_LIT_MSB:`FMM_CTRL_LIT_LSB]} : st.src;

  assign prod_u = st.dest[15:0] * src_val[15:0];
  assign prod_s = $signed(st.dest[15:0]) * $signed(src_val[15:0]);

  // Writeback at the end of the done step or the last multiply step
  assign wb = st.phase == fmm_pkg::FMM_DONE ||
              (st.phase == fmm_pkg::FMM_MULT &&
               st.mcount + 2'h1 >= `FMM_MUL_CYCLES);
  // Register writes only while nothing is pending
  assign wr_ok = st.phase == fmm_pkg::FMM_IDLE && !go;
  assign mod_c = wb && do_c && (op == fmm_pkg::FMM_OP_CARRY_MODIFY ||
                                op == fmm_pkg::FMM_OP_BOTH_FLAGS_MODIFY);

  ////////////////////////////////////////////////////////////////////////
  // Result and flag datapath
  always_comb begin
    res = st.dest;
    res_c = st.carry;
    res_z = st.zero;
    do_c = 1'b0;
    do_z = 1'b0;
    case (op)
      fmm_pkg::FMM_OP_CARRY_MODIFY: begin
        res_c = fmm_eval(ccode, st.carry, st.zero);
        do_c = wc;
      end
      fmm_pkg::FMM_OP_ZERO_FLAG_MODIFY: begin
        res_z = fmm_eval(zcode, st.carry, st.zero);
        do_z = wz;
      end
      fmm_pkg::FMM_OP_BOTH_FLAGS_MODIFY: begin
        res_c = fmm_eval(ccode, st.carry, st.zero);
        res_z = fmm_eval(zcode, st.carry, st.zero);
        do_c = wc;
        do_z = wz;
      end
      fmm_pkg::FMM_OP_COPY: begin
        res = src_val;
        res_c = src_val[31];
        res_z = (src_val == 32'h0000_0000);
        do_c = wc;
        do_z = wz;
      end
      fmm_pkg::FMM_OP_UNSIGNED_PRODUCT,
      fmm_pkg::FMM_OP_SIGNED_PRODUCT: begin
        res = st.product;
        res_z = (st.dest == 32'h0000_0000) ||
                (src_val == 32'h0000_0000);
        do_z = wz;
      end
      fmm_pkg::FMM_OP_CARRY_BIT_MERGE,
      fmm_pkg::FMM_OP_INVERTED_CARRY_MERGE: begin
        res = (st.dest & ~src_val) |
              (src_val & {32{st.carry ^
               (op == fmm_pkg::FMM_OP_INVERTED_CARRY_MERGE)}});
        res_c = ^res;
        res_z = (res == 32'h0000_0000);
        do_c = wc;
        do_z = wz;
      end
      fmm_pkg::FMM_OP_NIBBLE_MERGE: begin
        for (int n = 0; n < 8; n++) begin
          if (src_val[n*4 +: 4] != 4'h0) begin
            res[n*4 +: 4] = src_val[n*4 +: 4];
          end
        end
      end
      fmm_pkg::FMM_OP_BITPAIR_MERGE: begin
        for (int n = 0; n < 16; n++) begin
          if (src_val[n*2 +: 2] != 2'h0) begin
            res[n*2 +: 2] = src_val[n*2 +: 2];
          end
        end
      end
      default: begin
        res = st.dest;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and Avalon slave
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    case (st.phase)
      fmm_pkg::FMM_IDLE: begin
        if (go) begin
          if (op == fmm_pkg::FMM_OP_UNSIGNED_PRODUCT ||
              op == fmm_pkg::FMM_OP_SIGNED_PRODUCT) begin
            next_st.phase = fmm_pkg::FMM_MULT;
            next_st.mcount = 2'h1;
            next_st.product = (op == fmm_pkg::FMM_OP_SIGNED_PRODUCT) ?
                              prod_s : prod_u;
          end else begin
            next_st.phase = fmm_pkg::FMM_DONE;
          end
        end
      end
      fmm_pkg::FMM_MULT: begin
        next_st.mcount = st.mcount + 2'h1;
        if (wb) begin
          // Product latched on entry, so it retires like any other op
          next_st.phase = fmm_pkg::FMM_IDLE;
        end
      end
      fmm_pkg::FMM_DONE: begin
        next_st.phase = fmm_pkg::FMM_IDLE;
      end
      default: begin
        next_st.phase = fmm_pkg::FMM_IDLE;
      end
    endcase
    if (wb) begin
      next_st.dest = res;
      if (do_c) begin
        next_st.carry = res_c;
      end
      if (do_z) begin
        next_st.zero = res_z;
      end
      next_st.ctrl[`FMM_CTRL_GO] = 1'b0;
      next_st.mcount = 2'h0;
    end
    // Bus writes are held off while an instruction is in flight
    if (req.write && wr_ok) begin
      case (req.address)
        `FMM_OFS_CTRL: next_st.ctrl = fmm_lane(req.writedata, st.ctrl,
                                               req.byteenable);
        `FMM_OFS_DEST: next_st.dest = fmm_lane(req.writedata, st.dest,
                                               req.byteenable);
        `FMM_OFS_SRC: next_st.src = fmm_lane(req.writedata, st.src,
                                             req.byteenable);
        `FMM_OFS_FLAGS: begin
          if (req.byteenable[0]) begin
            next_st.carry = req.writedata[`FMM_FLAG_C];
            next_st.zero = req.writedata[`FMM_FLAG_Z];
          end
        end
        default: next_st.ctrl = st.ctrl;
      endcase
    end else if (req.read && !st.rvalid) begin
      case (req.address)
        `FMM_OFS_CTRL: next_st.rdata = st.ctrl;
        `FMM_OFS_DEST: next_st.rdata = st.dest;
        `FMM_OFS_SRC: next_st.rdata = st.src;
        `FMM_OFS_FLAGS: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rdata[`FMM_FLAG_C] = st.carry;
          next_st.rdata[`FMM_FLAG_Z] = st.zero;
          next_st.rdata[`FMM_FLAG_BUSY] = go;
        end
        default: next_st.rdata = 32'h0000_0000;
      endcase
      next_st.rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  // Writes land at the edge that sees waitrequest low
  assign avs_waitrequest = (avs_read && !st.rvalid) ||
                           (avs_write && !wr_ok);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence mul_start_s;
    st.phase == fmm_pkg::FMM_IDLE && go &&
    (op == fmm_pkg::FMM_OP_UNSIGNED_PRODUCT ||
     op == fmm_pkg::FMM_OP_SIGNED_PRODUCT);
  endsequence

  sequence mul_wb_s;
    st.phase == fmm_pkg::FMM_MULT && wb;
  endsequence

  sequence mul_done_s;
    st.phase == fmm_pkg::FMM_IDLE && !go;
  endsequence

  mul_latency_a: assert property (@(posedge clk) disable iff (reset)
    mul_start_s |-> ##1 mul_wb_s ##1 mul_done_s)
    else $error("multiply did not finish in two cycles");

  mul_product_a: assert property (@(posedge clk) disable iff (reset)
    (mul_start_s and (op == fmm_pkg::FMM_OP_UNSIGNED_PRODUCT)) |-> ##2
    st.dest == {16'h0000, $past(st.dest[15:0], 2)} *
               {16'h0000, $past(src_val[15:0], 2)})
    else $error("unsigned product wrong");

  smul_product_a: assert property (@(posedge clk) disable iff (reset)
    (mul_start_s and (op == fmm_pkg::FMM_OP_SIGNED_PRODUCT)) |-> ##2
    $signed(st.dest) == $past($signed(st.dest[15:0]), 2) *
                        $past($signed(src_val[15:0]), 2))
    else $error("signed product wrong");

  carry_hold_a: assert property (@(posedge clk) disable iff (reset)
    wb && !do_c |=> st.carry == $past(st.carry))
    else $error("carry changed without carry write");

  zero_hold_a: assert property (@(posedge clk) disable iff (reset)
    wb && !do_z |=> $stable(st.zero))
    else $error("zero changed without zero write");

  modify_carry_a: assert property (@(posedge clk) disable iff (reset)
    mod_c |=> st.carry == $past(ccode[{st.carry, st.zero}]))
    else $error("carry modify result wrong");

  modify_zero_a: assert property (@(posedge clk) disable iff (reset)
    wb && do_z && (op == fmm_pkg::FMM_OP_ZERO_FLAG_MODIFY ||
                   op == fmm_pkg::FMM_OP_BOTH_FLAGS_MODIFY)
    |=> st.zero == $past(zcode[{st.carry, st.zero}]))
    else $error("zero modify result wrong");

  force_low_a: assert property (@(posedge clk) disable iff (reset)
    mod_c && ccode == `FMM_FORCE_LOW_CODE |=> !st.carry)
    else $error("force low code did not clear carry");

  force_high_a: assert property (@(posedge clk) disable iff (reset)
    wb && do_z &&
    zcode == `FMM_FORCE_HIGH_CODE &&
    op == fmm_pkg::FMM_OP_ZERO_FLAG_MODIFY |=> st.zero)
    else $error("force high code did not set zero");

  copy_carry_a: assert property (@(posedge clk) disable iff (reset)
    mod_c && ccode == `FMM_COPY_CARRY_CODE |=> $stable(st.carry))
    else $error("carry copy code changed carry");

  invert_carry_a: assert property (@(posedge clk) disable iff (reset)
    mod_c && ccode == `FMM_INV_CARRY_CODE |=> st.carry != $past(st.carry))
    else $error("inverse carry code wrong");

  copy_zero_a: assert property (@(posedge clk) disable iff (reset)
    mod_c && ccode == `FMM_COPY_ZERO_CODE |=> st.carry == $past(st.zero))
    else $error("zero copy code wrong");

  equal_flags_a: assert property (@(posedge clk) disable iff (reset)
    mod_c && ccode == `FMM_C_EQ_Z_CODE
    |=> st.carry == ($past(st.carry) == $past(st.zero)))
    else $error("flag equality code wrong");

  copy_flags_a: assert property (@(posedge clk) disable iff (reset)
    wb && op == fmm_pkg::FMM_OP_COPY && wc
    |=> st.carry == $past(src_val[31]) && st.dest == $past(src_val))
    else $error("copy result or carry wrong");

  merge_mask_a: assert property (@(posedge clk) disable iff (reset)
    wb && (op == fmm_pkg::FMM_OP_CARRY_BIT_MERGE ||
           op == fmm_pkg::FMM_OP_INVERTED_CARRY_MERGE)
    |=> ((st.dest ^ $past(st.dest)) & ~$past(src_val)) == 32'h0000_0000)
    else $error("merge touched unmasked bits");

  merge_parity_a: assert property (@(posedge clk) disable iff (reset)
    wb && wc &&
    op == fmm_pkg::FMM_OP_CARRY_BIT_MERGE |=> st.carry == ^st.dest)
    else $error("merge parity wrong");

  nibble_flags_a: assert property (@(posedge clk) disable iff (reset)
    wb && op == fmm_pkg::FMM_OP_NIBBLE_MERGE
    |=> $stable(st.carry) && $stable(st.zero))
    else $error("nibble merge touched flags");

  bitpair_flags_a: assert property (@(posedge clk) disable iff (reset)
    wb && op == fmm_pkg::FMM_OP_BITPAIR_MERGE
    |=> $stable(st.carry) && $stable(st.zero))
    else $error("bit-pair merge touched flags");

  mul_zero_a: assert property (@(posedge clk) disable iff (reset)
    wb && wz && (op == fmm_pkg::FMM_OP_UNSIGNED_PRODUCT ||
                 op == fmm_pkg::FMM_OP_SIGNED_PRODUCT) &&
    (st.dest == 32'h0000_0000 || src_val == 32'h0000_0000)
    |=> st.zero)
    else $error("multiply zero flag wrong");

endmodule : fmm_alu

`default_nettype wire

// [verif/fmm_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Decode side of the core: issues register bus accesses to the block
module fmm_core_model (
  input wire logic clk,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  output var fmm_pkg::fmm_avl_req_t req
);

  initial req = '0;

  // One whole access; held until waitrequest is seen low at an edge
  task automatic access(input logic [3:0] a, input logic wr,
                        input logic [31:0] d, output logic [31:0] q);
    req.address <= a;
    req.read <= !wr;
    req.write <= wr;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    q = readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask : access

endmodule : fmm_core_model

`default_nettype wire

// [verif/test_flag_modifier_mul_mux_alu.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fmm_alu_map.svh"

module test_flag_modifier_mul_mux_alu;
  logic clk;
  logic reset;
  logic [3:0] cond_code;
  logic cond_true;
  logic [31:0] rdata;
  logic wait_r;
  logic [31:0] v;
  fmm_pkg::fmm_avl_req_t req;
  int error_cnt = 0;
  int checked = 0;

  fmm_alu dut (
    .clk(clk),
    .reset(reset),
    .avs_address(req.address),
    .avs_read(req.read),
    .avs_write(req.write),
    .avs_writedata(req.writedata),
    .avs_byteenable(req.byteenable),
    .avs_readdata(rdata),
    .avs_waitrequest(wait_r),
    .cond_code(cond_code),
    .cond_true(cond_true)
  );

  fmm_core_model core (
    .clk(clk),
    .readdata(rdata),
    .waitrequest(wait_r),
    .req(req)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    core.access(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    core.access(a, 1'b0, 32'h0, q);
  endtask : rd

  function automatic logic [31:0] cw(input logic [3:0] op,
      input logic [1:0] wzc, input logic imm, input logic [3:0] cc,
      input logic [3:0] zc, input logic [8:0] lit);
    return {7'h00, lit, zc, cc, 1'b0, imm, wzc, op};
  endfunction : cw

  // Start an instruction and poll until it is no longer busy
  task automatic run(input logic [31:0] c);
    logic [31:0] f;
    wr(`FMM_OFS_CTRL, c | 32'h8000_0000);
    rd(`FMM_OFS_FLAGS, f);
    while (f[`FMM_FLAG_BUSY]) rd(`FMM_OFS_FLAGS, f);
  endtask : run

  task automatic exp_run(input logic [31:0] c, input logic [31:0] d,
                         input logic [1:0] cz);
    logic [31:0] r;
    run(c);
    rd(`FMM_OFS_DEST, r);
    chk(r, d);
    rd(`FMM_OFS_FLAGS, r);
    chk({30'h0, r[1:0]}, {30'h0, cz});
  endtask : exp_run

  task automatic summarize;
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    error_cnt++;
    summarize();
  end

  initial begin
    logic [3:0] cd;
    logic ex;
    reset = 1'b1;
    cond_code = 4'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Every code against every carry and zero state
    for (int k = 0; k < 16; k++) begin
      for (int s = 0; s < 4; s++) begin
        cd = k[3:0];
        ex = cd[s[1:0]];
        wr(`FMM_OFS_FLAGS, 32'(s));
        cond_code <= cd;
        @(negedge clk);
        chk({31'h0, cond_true}, {31'h0, ex});
        @(posedge clk);
        exp_run(cw(fmm_pkg::FMM_OP_BOTH_FLAGS_MODIFY, 2'b11, 1'b0, cd,
                   cd, 9'h0), 32'h0, {ex, ex});
      end
    end
    // Codes above as well
    wr(`FMM_OFS_FLAGS, 32'h0);
    exp_run(cw(fmm_pkg::FMM_OP_CARRY_MODIFY, 2'b01, 1'b0, 4'hf, 4'hf,
               9'h0), 32'h0, 2'b10);
    exp_run(cw(fmm_pkg::FMM_OP_ZERO_FLAG_MODIFY, 2'b10, 1'b0, 4'h0, 4'hf,
               9'h0), 32'h0, 2'b11);
    exp_run(cw(fmm_pkg::FMM_OP_BOTH_FLAGS_MODIFY, 2'b00, 1'b0, 4'h0,
               4'h0, 9'h0), 32'h0, 2'b11);
    // Copy from register, then from literal
    wr(`FMM_OFS_SRC, 32'h8000_0000);
    exp_run(cw(fmm_pkg::FMM_OP_COPY, 2'b11, 1'b0, 4'h0, 4'h0, 9'h0),
            32'h8000_0000, 2'b10);
    exp_run(cw(fmm_pkg::FMM_OP_COPY, 2'b11, 1'b1, 4'h0, 4'h0, 9'h1ff),
            32'h0000_01ff, 2'b00);
    exp_run(cw(fmm_pkg::FMM_OP_COPY, 2'b11, 1'b1, 4'h0, 4'h0, 9'h0),
            32'h0, 2'b01);
    // Products
    wr(`FMM_OFS_DEST, 32'h1234_ffff);
    wr(`FMM_OFS_SRC, 32'habcd_ffff);
    exp_run(cw(fmm_pkg::FMM_OP_UNSIGNED_PRODUCT, 2'b10, 1'b0, 4'h0, 4'h0,
               9'h0), 32'hfffe_0001, 2'b00);
    wr(`FMM_OFS_DEST, 32'hffff_0003);
    wr(`FMM_OFS_SRC, 32'h0);
    exp_run(cw(fmm_pkg::FMM_OP_UNSIGNED_PRODUCT, 2'b10, 1'b0, 4'h0, 4'h0,
               9'h0), 32'h0, 2'b01);
    wr(`FMM_OFS_DEST, 32'h0000_ffff);
    wr(`FMM_OFS_SRC, 32'h7fff_0003);
    exp_run(cw(fmm_pkg::FMM_OP_SIGNED_PRODUCT, 2'b10, 1'b0, 4'h0, 4'h0,
               9'h0), 32'hffff_fffd, 2'b00);
    wr(`FMM_OFS_DEST, 32'h0000_8000);
    exp_run(cw(fmm_pkg::FMM_OP_SIGNED_PRODUCT, 2'b10, 1'b1, 4'h0, 4'h0,
               9'h002), 32'hffff_0000, 2'b00);
    // Carry merges with parity and zero flags
    wr(`FMM_OFS_FLAGS, 32'h2);
    wr(`FMM_OFS_DEST, 32'h0f0f_0000);
    wr(`FMM_OFS_SRC, 32'h0000_00ff);
    exp_run(cw(fmm_pkg::FMM_OP_CARRY_BIT_MERGE, 2'b11, 1'b0, 4'h0, 4'h0,
               9'h0), 32'h0f0f_00ff, 2'b00);
    wr(`FMM_OFS_SRC, 32'h0000_0100);
    exp_run(cw(fmm_pkg::FMM_OP_INVERTED_CARRY_MERGE, 2'b11, 1'b0, 4'h0,
               4'h0, 9'h0), 32'h0f0f_01ff, 2'b10);
    wr(`FMM_OFS_SRC, 32'hffff_ffff);
    exp_run(cw(fmm_pkg::FMM_OP_INVERTED_CARRY_MERGE, 2'b11, 1'b0, 4'h0,
               4'h0, 9'h0), 32'h0, 2'b01);
    // Group merges leave the flags alone even with writes requested
    wr(`FMM_OFS_DEST, 32'h1234_5678);
    wr(`FMM_OFS_SRC, 32'h00f0_000a);
    exp_run(cw(fmm_pkg::FMM_OP_NIBBLE_MERGE, 2'b11, 1'b0, 4'h0, 4'h0,
               9'h0), 32'h12f4_567a, 2'b01);
    wr(`FMM_OFS_DEST, 32'hffff_ffff);
    wr(`FMM_OFS_SRC, 32'h0000_0012);
    exp_run(cw(fmm_pkg::FMM_OP_BITPAIR_MERGE, 2'b11, 1'b0, 4'h0, 4'h0,
               9'h0), 32'hffff_ffde, 2'b01);
    summarize();
  end

endmodule : test_flag_modifier_mul_mux_alu

`default_nettype wire
